// >>> design/asc_params.svh
// Timing and field constants for the asynchronous SRAM controller
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
`define ASC_CLK_NS        8
`define ASC_ADDR_W        20
`define ASC_DATA_W        16
`define ASC_CNT_W         20
`define ASC_ADDR_LSB_BIT  15
`define ASC_T_CW_NS       70
`define ASC_T_RC_NS       85
`define ASC_T_HZ_NS       30
`define ASC_SYNC_STAGES   3
`define ASC_T_REC_MS      5
`define ASC_NS_PER_MS     1000000
`define ASC_LANES_OFF     2'h3
`define ASC_LANES_BOTH    2'h0
`endif

// >>> design/asc_pkg.sv
// Types shared by the asynchronous SRAM controller modules
`default_nettype none
`include "asc_params.svh"
package asc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WEND, ST_READ, ST_TURN, ST_SLEEP, ST_WAIT
   } asc_state_type;

   typedef struct packed {
      asc_state_type            state;
      logic                     selectOneN;
      logic                     selectTwo;
      logic                     writeEnN;
      logic                     outEnN;
      logic                     byteModeN;
      logic [1:0]               lanesN;
      logic [`ASC_ADDR_W-1:0]   wordAddress;
      logic [`ASC_DATA_W-1:0]   dataOut;
      logic [`ASC_DATA_W-1:0]   dataOe;
      logic [`ASC_DATA_W-1:0]   sync1;
      logic [`ASC_DATA_W-1:0]   sync2;
      logic [`ASC_DATA_W-1:0]   respData;
      logic                     respValid;
   } asc_ctrl_type;

   typedef struct packed {
      logic [`ASC_CNT_W-1:0] cnt;
   } asc_tmr_type;
endpackage
`default_nettype wire

// >>> design/asc_tmr_if.sv
// Load and done handshake between controller and wait timer
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"
interface asc_tmr_if;
   logic                  load;
   logic [`ASC_CNT_W-1:0] count;
   logic                  done;
   modport ctrl (output load, output count, input done);
   modport tmr  (input load, input count, output done);
endinterface
`default_nettype wire

// >>> design/asc_timer.sv
// Down counter that times every controller wait
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"
module asc_timer
   import asc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Controller side
   asc_tmr_if.tmr    tmr
);
   asc_tmr_type s_r;
   asc_tmr_type s_nxt;

   // ========================================
   // Count down
   always_comb begin
      s_nxt = s_r;
      if (tmr.load) begin
         s_nxt.cnt = tmr.count;
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - `ASC_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tmr.done = (s_r.cnt == '0);
endmodule
`default_nettype wire

// >>> design/asc_ctrl.sv
// Host controller that drives an asynchronous 1M x 16 static RAM
// How it works
// [RQ1] Memory holds 1048576 sixteen-bit words at a 20-bit word address.
// [RQ2] Memory needs no clock or refresh; pins alone define operations.
// [RQ3] Select one high, select two low, or both lanes high means standby.
// [RQ4] Reads drive only lanes selected low; output enable high floats all.
// [RQ5] Memory drives data only while output enable is low in a read.
// [RQ6] Byte mode uses bits 7..0, floats 14..8, bit 15 is lowest address.
// [RQ7] In byte mode the controller holds both lane selects low during accesses, high between them.
// [RQ8] A write needs both selects active, write enable and a lane low.
// [RQ9] Write starts at last asserting edge; overlap at least 55/60 ns.
// [RQ10] Write ends at first deasserting edge of any select or enable.
// [RQ11] Chip and lane selection precede end of write by 65/70 ns.
// [RQ12] Address valid at write start and 65 ns before end; cycle 70 ns.
// [RQ13] Address may change right after write ends; zero recovery.
// [RQ14] Write data valid 35/40 ns before end of write, zero hold.
// [RQ15] Memory floats within 25 ns of write enable, redrives after 5 ns.
// [RQ16] Read data within 70/85 ns of address or selects; cycle as long.
// [RQ17] Read data within 35/45 ns of output enable falling.
// [RQ18] Old read data stays valid 10 ns after an address change.
// [RQ19] Memory outputs turn off faster than they turn on.
// [RQ20] Select two low gates all inputs; others may float in retention.
// [RQ21] Retention by select one needs select two at a firm level.
// [RQ22] Retention may start at once; wait 5 ms after leaving it.
// [RQ23] Output enable stays high during writes the controller drives.
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"
module asc_ctrl
   import asc_pkg::*;
#(
   parameter int WAIT_CYCLES = (`ASC_T_REC_MS * `ASC_NS_PER_MS) / `ASC_CLK_NS
)
(
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   // User request
   input  wire logic                   reqValid,
   output logic                        reqReady,
   input  wire logic                   reqWrite,
   input  wire logic [`ASC_ADDR_W-1:0] reqAddr,
   input  wire logic                   reqAddrLsb,
   input  wire logic [1:0]             reqLanes,
   input  wire logic                   reqByteMode,
   input  wire logic [`ASC_DATA_W-1:0] reqWdata,
   input  wire logic                   sleepReq,
   // User answer
   output logic [`ASC_DATA_W-1:0]      respData,
   output logic                        respValid,
   output logic                        asleep,
   // Memory pins
   output logic                        select_one_n,
   output logic                        select_two,
   output logic                        writeEnN,
   output logic                        outEnN,
   output logic                        byteModeN,
   output logic                        lower_lane_select_n,
   output logic                        upper_lane_select_n,
   output logic [`ASC_ADDR_W-1:0]      word_address,
   output logic [`ASC_DATA_W-1:0]      data_pins_out,
   output logic [`ASC_DATA_W-1:0]      data_pins_oe,
   input  wire logic [`ASC_DATA_W-1:0] data_pins_in
);
   // ========================================
   // Cycle counts, least times rounded up
   localparam int WrCycles = (`ASC_T_CW_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS;
   localparam int RdCycles = (`ASC_T_RC_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS + `ASC_SYNC_STAGES;
   localparam int HzCycles = (`ASC_T_HZ_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS;

   asc_ctrl_type s_r;
   asc_ctrl_type s_nxt;
   asc_tmr_if    tmrIf ();

   asc_timer u_timer (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tmr     (tmrIf.tmr)
   );

   function automatic logic [`ASC_DATA_W-1:0] laneMask(input logic byteN, input logic [1:0] lanesN);
      logic [`ASC_DATA_W-1:0] m;
      m = {{8{~lanesN[1]}}, {8{~lanesN[0]}}};
      if (!byteN) begin
         m = {1'b1, 7'h00, 8'hFF};
      end
      return m;
   endfunction

   function automatic logic [`ASC_CNT_W-1:0] waitOf(input int cycles);
      return `ASC_CNT_W'(cycles - 1);
   endfunction

   // ========================================
   // Sequencer
   always_comb begin
      s_nxt           = s_r;
      s_nxt.sync1     = data_pins_in;
      s_nxt.sync2     = s_r.sync1;
      s_nxt.respValid = 1'b0;
      tmrIf.load      = 1'b0;
      tmrIf.count     = '0;
      case (s_r.state)
         ST_IDLE: begin
            if (sleepReq) begin
               s_nxt.selectTwo = 1'b0; // RQ20 RQ22
               s_nxt.state     = ST_SLEEP;
            end else if (reqValid && (reqByteMode == s_r.byteModeN)) begin
               // Mode change settles before any access
               s_nxt.byteModeN = ~reqByteMode;
               tmrIf.load      = 1'b1;
               tmrIf.count     = waitOf(WAIT_CYCLES);
               s_nxt.state     = ST_WAIT;
            end else if (reqValid) begin
               s_nxt.wordAddress = reqAddr; // RQ1 RQ12
               s_nxt.selectOneN  = 1'b0;
               s_nxt.lanesN      = reqByteMode ? `ASC_LANES_BOTH : ~reqLanes; // RQ7
               s_nxt.dataOut     = reqWdata;
               s_nxt.dataOe      = '0;
               if (reqByteMode) begin
                  s_nxt.dataOut[`ASC_ADDR_LSB_BIT] = reqAddrLsb; // RQ6
                  s_nxt.dataOe[`ASC_ADDR_LSB_BIT]  = 1'b1;
               end
               if (reqWrite) begin
                  s_nxt.state = ST_WSETUP;
               end else begin
                  s_nxt.outEnN = 1'b0; // RQ4 RQ5
                  tmrIf.load   = 1'b1;
                  tmrIf.count  = waitOf(RdCycles); // RQ16 RQ17
                  s_nxt.state  = ST_READ;
               end
            end
         end
         ST_WSETUP: begin
            // Memory never drove: output enable has been high all along
            s_nxt.writeEnN = 1'b0; // RQ8 RQ9 RQ23
            s_nxt.dataOe   = laneMask(s_r.byteModeN, s_r.lanesN); // RQ14
            tmrIf.load     = 1'b1;
            tmrIf.count    = waitOf(WrCycles); // RQ9 RQ11 RQ12
            s_nxt.state    = ST_WPULSE;
         end
         ST_WPULSE: begin
            if (tmrIf.done) begin
               s_nxt.writeEnN = 1'b1; // RQ10
               s_nxt.state    = ST_WEND;
            end
         end
         ST_WEND: begin
            // Data and address held one cycle past the end of write
            s_nxt.selectOneN = 1'b1; // RQ13 RQ14
            s_nxt.lanesN     = `ASC_LANES_OFF;
            s_nxt.dataOe     = '0;
            s_nxt.state      = ST_IDLE;
         end
         ST_READ: begin
            if (tmrIf.done) begin
               s_nxt.respData   = s_r.sync2 & laneMask(s_r.byteModeN, s_r.lanesN)
                                  & {!s_r.byteModeN ? 1'b0 : 1'b1, 15'h7FFF}; // RQ4 RQ18
               s_nxt.respValid  = 1'b1;
               s_nxt.outEnN     = 1'b1;
               s_nxt.selectOneN = 1'b1; // RQ3
               s_nxt.lanesN     = `ASC_LANES_OFF;
               s_nxt.dataOe     = '0;
               tmrIf.load       = 1'b1;
               tmrIf.count      = waitOf(HzCycles); // RQ19
               s_nxt.state      = ST_TURN;
            end
         end
         ST_TURN: begin
            if (tmrIf.done) begin
               s_nxt.state = ST_IDLE;
            end
         end
         ST_SLEEP: begin
            if (!sleepReq) begin
               s_nxt.selectTwo = 1'b1;
               tmrIf.load      = 1'b1;
               tmrIf.count     = waitOf(WAIT_CYCLES); // RQ22
               s_nxt.state     = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (tmrIf.done) begin
               s_nxt.state = ST_IDLE;
            end
         end
         default: begin
            s_nxt.state = ST_IDLE;
         end
      endcase
   end

   // ========================================
   // State register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r            <= '0;
         s_r.state      <= ST_IDLE;
         s_r.selectOneN <= 1'b1;
         s_r.selectTwo  <= 1'b1;
         s_r.writeEnN   <= 1'b1;
         s_r.outEnN     <= 1'b1;
         s_r.byteModeN  <= 1'b1;
         s_r.lanesN     <= `ASC_LANES_OFF;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Ready only when idle, awake and in the asked mode
   assign reqReady            = (s_r.state == ST_IDLE) && !sleepReq && (reqByteMode != s_r.byteModeN);
   assign respData            = s_r.respData;
   assign respValid           = s_r.respValid;
   assign asleep              = (s_r.state == ST_SLEEP);
   assign select_one_n        = s_r.selectOneN;
   assign select_two          = s_r.selectTwo; // RQ21
   assign writeEnN            = s_r.writeEnN;
   assign outEnN              = s_r.outEnN;
   assign byteModeN           = s_r.byteModeN;
   assign lower_lane_select_n = s_r.lanesN[0];
   assign upper_lane_select_n = s_r.lanesN[1];
   assign word_address        = s_r.wordAddress;
   assign data_pins_out       = s_r.dataOut;
   assign data_pins_oe        = s_r.dataOe;

   // ========================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence wrLow9;
      !writeEnN [*8] ##1 !writeEnN;
   endsequence

   write_pulse_a : assert property ($fell(writeEnN) |-> wrLow9) // RQ9
      else $error("write pulse shorter than nine cycles");
   oe_in_write_a : assert property (!writeEnN |-> outEnN) // RQ23
      else $error("output enable low during write");
   sel_before_we_a : assert property ($fell(writeEnN) |-> $past(!select_one_n) && select_two) // RQ11
      else $error("select not set before write enable");
   addr_hold_a : assert property (!writeEnN |=> $stable(word_address)) // RQ12
      else $error("address moved during write");
   data_hold_a : assert property ($rose(writeEnN) |-> $stable(data_pins_out) && data_pins_oe != '0) // RQ14
      else $error("write data not held at end of write");
   byte_lanes_a : assert property (!byteModeN && !select_one_n |-> !lower_lane_select_n && !upper_lane_select_n) // RQ7
      else $error("lanes not both low in byte mode");
   wake_wait_a : assert property ($rose(select_two) |-> select_one_n [*8]) // RQ22
      else $error("access too soon after retention");
   read_float_a : assert property (!outEnN |-> data_pins_oe[7:0] == 8'h00 && writeEnN) // RQ5
      else $error("controller drives data during read");
   read_len_a : assert property ($fell(outEnN) |-> !outEnN [*8] ##1 !outEnN [*5]) // RQ16
      else $error("read strobe shorter than access time");
endmodule
`default_nettype wire

// >>> testbench/asc_sram_model.sv
// Behavioural asynchronous static RAM seen by the controller
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model #(
   parameter int T_ACC = 85
)
(
   // Control pins
   input  wire logic        select_one_n,
   input  wire logic        select_two,
   input  wire logic        writeEnN,
   input  wire logic        outEnN,
   input  wire logic        byteModeN,
   input  wire logic [1:0]  lanesN,
   // Address and data
   input  wire logic [19:0] word_address,
   input  wire logic [15:0] data_pins,
   output logic [15:0]      drvOut,
   output logic [15:0]      drvOe
);
   logic [15:0] mem [int];
   logic [15:0] latD, w, rd;
   logic [19:0] latA;
   logic [1:0]  latL;
   logic        latB, sel, wrAct, rdAct;
   realtime     tStart;
   assign sel   = !select_one_n && select_two;
   assign wrAct = sel && !writeEnN && lanesN != 2'h3;
   assign rdAct = sel && writeEnN && !outEnN && lanesN != 2'h3;
   always @* if (wrAct) begin
      latD = data_pins;
      latA = word_address;
      latL = lanesN;
      latB = byteModeN;
   end
   // ==================================================
   // Commit at the first deasserting edge
   always @(negedge wrAct) begin
      w = mem.exists(int'(latA)) ? mem[int'(latA)] : 16'h0000;
      if (!latB && latD[15]) w[15:8] = latD[7:0];
      else if (!latB) w[7:0] = latD[7:0];
      else w = {latL[1] ? w[15:8] : latD[15:8], latL[0] ? w[7:0] : latD[7:0]};
      mem[int'(latA)] = w;
   end
   // Wrong data until access time: no kinder than silicon
   always @(word_address, rdAct, lanesN) tStart = $realtime;
   always #1 begin
      rd = mem.exists(int'(word_address)) ? mem[int'(word_address)] : 16'h0000;
      if (!byteModeN) rd = {8'h00, data_pins[15] ? rd[15:8] : rd[7:0]};
      if ($realtime - tStart < T_ACC) rd = ~rd;
      drvOut = rd;
      drvOe  = !rdAct ? 16'h0000 : !byteModeN ? 16'h00FF : {{8{!lanesN[1]}}, {8{!lanesN[0]}}};
   end
endmodule
`default_nettype wire

// >>> testbench/async_sram_1m_x16_tb_top.sv
// Self-checking bench for the asynchronous SRAM controller
`timescale 1ns/1ps
`default_nettype none
module async_sram_1m_x16_tb_top;
   logic        clk_sys, rst_b, reqValid, reqReady, reqWrite, reqAddrLsb, reqByteMode, sleepReq;
   logic        respValid, asleep, selOneN, selTwo, writeEnN, outEnN, byteModeN, lowN, upN;
   logic [19:0] reqAddr, wordAddress, a2;
   logic [1:0]  reqLanes;
   logic [15:0] reqWdata, respData, pinsOut, pinsOe, pins, memOut, memOe, junk;
   logic [15:0] shadow [int];
   logic [31:0] seed;
   int          n_errors, n_compared, cyc, weLow;
   // ==================================================
   // Pin resolution: a floating bit toggles every cycle
   assign pins = (pinsOe & pinsOut) | (~pinsOe & memOe & memOut) | (~pinsOe & ~memOe & junk);
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) junk <= ~junk;
   asc_ctrl #(.WAIT_CYCLES(20)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .reqValid(reqValid),
      .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqAddrLsb(reqAddrLsb),
      .reqLanes(reqLanes), .reqByteMode(reqByteMode), .reqWdata(reqWdata), .sleepReq(sleepReq),
      .respData(respData), .respValid(respValid), .asleep(asleep), .select_one_n(selOneN),
      .select_two(selTwo), .writeEnN(writeEnN), .outEnN(outEnN), .byteModeN(byteModeN),
      .lower_lane_select_n(lowN), .upper_lane_select_n(upN), .word_address(wordAddress),
      .data_pins_out(pinsOut), .data_pins_oe(pinsOe), .data_pins_in(pins));
   asc_sram_model mdl (.select_one_n(selOneN), .select_two(selTwo), .writeEnN(writeEnN),
      .outEnN(outEnN), .byteModeN(byteModeN), .lanesN({upN, lowN}), .word_address(wordAddress),
      .data_pins(pins), .drvOut(memOut), .drvOe(memOe));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // ==================================================
   // One request; reads are compared with the shadow copy
   task automatic op(input logic wr, input logic [19:0] a, input logic lsb, input logic [1:0] ln,
                     input logic bm, input logic [15:0] wd);
      int          k;
      logic [15:0] w;
      @(negedge clk_sys);
      {reqValid, reqWrite, reqAddr, reqAddrLsb, reqLanes, reqByteMode, reqWdata} = {1'b1, wr, a, lsb, ln, bm, wd};
      k = 0;
      #1;
      while (reqReady !== 1'b1 && k < 300) begin
         @(negedge clk_sys);
         #1;
         k++;
      end
      chk(16'(k < 300), 16'h0001);
      @(negedge clk_sys);
      reqValid = 1'b0;
      w = shadow.exists(int'(a)) ? shadow[int'(a)] : 16'h0000;
      if (wr && bm && lsb) w[15:8] = wd[7:0];
      else if (wr && bm) w[7:0] = wd[7:0];
      else if (wr) w = {ln[1] ? wd[15:8] : w[15:8], ln[0] ? wd[7:0] : w[7:0]};
      if (wr) shadow[int'(a)] = w;
      else begin
         k = 1;
         while (respValid !== 1'b1 && k < 40) begin
            @(negedge clk_sys);
            k++;
         end
         chk(16'(k), 16'h000F);
         chk(respData, bm ? {8'h00, lsb ? w[15:8] : w[7:0]} : w & {{8{ln[1]}}, {8{ln[0]}}});
      end
   endtask
   // ==================================================
   // Pin watchers and hang limit
   always @(negedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim;
      end else begin
         if (rst_b) chk(pinsOe & memOe, 16'h0000);
         if (writeEnN === 1'b0) begin
            weLow++;
            chk(16'(outEnN), 16'h0001);
            if (byteModeN === 1'b0) chk(16'({upN, lowN}), 16'h0000);
         end else if (weLow != 0) begin
            chk(16'(weLow * 8 >= 60), 16'h0001);
            weLow = 0;
         end
      end
   end
   initial begin
      {clk_sys, rst_b, reqValid, reqWrite, reqAddrLsb, reqByteMode, sleepReq} = 7'h00;
      {reqAddr, reqLanes, reqWdata, junk} = 54'h0;
      seed = 32'h5817;
      {n_errors, n_compared, cyc, weLow} = 128'h0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      chk(16'({selOneN, selTwo, outEnN, writeEnN, byteModeN, lowN, upN}), 16'h007F);
      chk(pinsOe, 16'h0000);
      $display("test reset done");
      op(1'b1, 20'h00000, 1'b0, 2'h3, 1'b0, 16'hA5C3);
      op(1'b1, 20'hFFFFF, 1'b0, 2'h3, 1'b0, 16'h5A3C);
      op(1'b0, 20'h00000, 1'b0, 2'h3, 1'b0, 16'h0000);
      op(1'b0, 20'hFFFFF, 1'b0, 2'h1, 1'b0, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         a2 = {16'h0000, seed[9:6]};
         op(1'b1, {16'h0000, seed[3:0]}, 1'b0, seed[4] ? 2'h3 : {seed[5], ~seed[5]}, 1'b0, seed[31:16]);
         op(1'b0, a2, 1'b0, seed[10] ? 2'h3 : {seed[11], ~seed[11]}, 1'b0, 16'h0000);
      end
      $display("test word traffic done");
      op(1'b1, 20'h00003, 1'b0, 2'h0, 1'b1, 16'h0011);
      op(1'b1, 20'h00003, 1'b1, 2'h0, 1'b1, 16'h0022);
      op(1'b0, 20'h00003, 1'b1, 2'h0, 1'b1, 16'h0000);
      op(1'b0, 20'h00003, 1'b0, 2'h0, 1'b1, 16'h0000);
      op(1'b0, 20'h00003, 1'b0, 2'h3, 1'b0, 16'h0000);
      $display("test byte mode done");
      @(negedge clk_sys);
      sleepReq = 1'b1;
      // Read turnaround still runs for three cycles before idle
      repeat (6) @(negedge clk_sys);
      chk(16'({asleep, selTwo}), 16'h0002);
      sleepReq = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(16'(reqReady), 16'h0000);
      op(1'b0, 20'h00000, 1'b0, 2'h3, 1'b0, 16'h0000);
      $display("test retention done");
      end_sim;
   end
endmodule
`default_nettype wire
